// ---- pkg/mbb_pkg.sv ----
// Constants shared by the background generator and its bypass bank.
// Assumes a 25 MHz core clock and a 32-bit APB register port.
package mbb_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BG_A = 8'h04;
  localparam logic [7:0] OFF_BG_B = 8'h08;
  localparam logic [7:0] OFF_HOLD = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  // Control field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_ALT_INV = 1;
  localparam int CTRL_COL_INV = 2;
  localparam int CTRL_BGSEL_LO = 3;
  localparam int CTRL_CUSTOM = 5;
  localparam int CTRL_TWO_CUSTOM = 6;
  localparam int CTRL_HANDSHAKE = 7;
  localparam int CTRL_BYPASS = 8;
  localparam int CTRL_MEM_DIS = 9;
  localparam int CTRL_W = 10;
  // Status field positions
  localparam int STAT_BUSY = 8;
  localparam int STAT_DONE = 9;
  localparam int STAT_FAIL = 10;
  localparam int STAT_PAUSE = 11;
  localparam int STAT_IDX_LO = 12;
  localparam int STAT_ADDR_LO = 16;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [31:0] HOLD_RST = 32'h00000000;
  // Background selection codes
  localparam logic [1:0] BGSEL_BOTH0 = 2'h0;
  localparam logic [1:0] BGSEL_UNIFORM = 2'h1;
  localparam logic [1:0] BGSEL_CHECKER = 2'h2;
  // Bypass construction kinds
  localparam int BYP_NONE = 0;
  localparam int BYP_WIRE = 1;
  localparam int BYP_REG = 2;
  // Timing: default pause is a least time, so it rounds up
  localparam longint CLK_PERIOD_PS = 40000;
  localparam longint HOLD_DEFAULT_PS = 1000000000;
  localparam logic [31:0] HOLD_DEFAULT_CYC =
    32'((HOLD_DEFAULT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_WRB = 8'h02,
    ST_P1 = 8'h04,
    ST_RDB = 8'h08,
    ST_WRA = 8'h10,
    ST_P2 = 8'h20,
    ST_RDA = 8'h40,
    ST_DONE = 8'h80
  } mbb_state_t;
endpackage : mbb_pkg

// ---- pkg/mbb_byp_if.sv ----
// Link between the core and the bypass register bank.
// Assumes both ends run on core_clk.
interface mbb_byp_if #(
  parameter int DW = 8
);
  logic [DW-1:0] merged;
  logic capEn;
  logic [DW-1:0] q;
  modport core (output merged, output capEn, input q);
  modport bank (input merged, input capEn, output q);
endinterface : mbb_byp_if

// ---- core/mbb_bypass_bank.sv ----
// Bypass observation bank: folds merged memory inputs into shared registers.
// Assumes capEn is a single-cycle strobe from core_clk logic.
module mbb_bypass_bank #(
  parameter int DW = 8,
  parameter int SHARE = 4,
  parameter int KIND = mbb_pkg::BYP_REG
) (
  input wire logic core_clk,
  input wire logic resetn,
  mbb_byp_if.bank byp
);
  localparam int NREG = (DW + SHARE - 1) / SHARE;

  typedef struct packed {
    logic [NREG-1:0] bits;
  } mbb_bank_st_t;

  mbb_bank_st_t r_reg;
  mbb_bank_st_t r_next;

  // Each register holds the parity of the SHARE bits it covers
  always_comb
  begin
    r_next = r_reg;
    if (byp.capEn)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        r_next.bits[i] = 1'b0;
        for (int j = 0; j < SHARE; j++)
        begin
          if (i * SHARE + j < DW)
          begin
            r_next.bits[i] = r_next.bits[i] ^ byp.merged[i * SHARE + j];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // Shared register fans back out to every bit it covers
  always_comb
  begin
    for (int k = 0; k < DW; k++)
    begin
      if (KIND == mbb_pkg::BYP_REG)
        byp.q[k] = r_reg.bits[k / SHARE];
      else
        byp.q[k] = byp.merged[k];
    end
  end
endmodule : mbb_bypass_bank

// ---- core/mbb_top.sv ----
// Data-background generator, retention pause timer and memory bypass.
// Assumes the RAM and functional logic run on core_clk; APB master drives regs.
// Contract
// R1 - Alternate-address inversion: even addresses plain, odd addresses inverted.
// R2 - Column inversion flips data every column-mux-ratio addresses.
// R3 - Uniform kind with custom value uses that value as sole word.
// R4 - Checker with one custom value: value, inverse, 0x5 word, 0xA word.
// R5 - Checker with two custom values: first, inverse, second, inverse.
// R6 - Hold modes: fixed time, or handshake with the test environment.
// R7 - Pause defaults to 1ms; longer configured hold replaces it.
// R8 - Sequence: write b down, pause, read b down, write a up, pause, read a up.
// R9 - Bypass may be absent, wired or registered; absent means no bypass.
// R10 - Bypass merges all memory inputs into the read-data output path.
// R11 - With bypass and multiple clocks, scan clock switches to test clock.
// R12 - Memory-disable option holds chip select at its inactive level.
// R13 - Memory-disable option ties memory clocks low during bypass.
// R14 - Registered bypass shares one register among a chosen number of bits.
// R15 - Registered bypass may be timed by a dedicated outside input.
// R16 - Functional-clock tie, with clock tracing, drives test clock from functional.
// R17 - Background select: 00 both, 01 uniform, 10 checker, 11 both.
// R18 - Both inversions together combine by exclusive-OR.
// R19 - Handshake pause raises a request and resumes on acknowledge.
//
// The register offsets and register access over APB were decided locally.
module mbb_top #(
  parameter int DW = 8,
  parameter int AW = 6,
  parameter int COL_MUX = 4,
  parameter int SHARE = 4,
  parameter int BYPASS_KIND = mbb_pkg::BYP_REG,
  parameter bit CS_ACT_HIGH = 1'b1,
  parameter bit DED_BYP_CLK = 1'b1,
  parameter bit MULTI_CLK = 1'b1,
  parameter bit FUNC_CLK_TIE = 1'b0,
  parameter bit CLOCK_TRACE = 1'b1,
  parameter logic [31:0] HOLD_CYCLES = mbb_pkg::HOLD_DEFAULT_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [AW-1:0] funcAddr,
  input wire logic [DW-1:0] funcWData,
  input wire logic funcWe,
  input wire logic funcCs,
  output logic [DW-1:0] funcRData,
  output logic [AW-1:0] memAddr,
  output logic [DW-1:0] memWData,
  output logic memWe,
  output logic memCs,
  input wire logic [DW-1:0] memRData,
  output logic memClkTieLow,
  output logic memClkUseTest,
  output logic testClkFromFunc,
  output logic scanClkToTest,
  output logic pauseReq,
  input wire logic pauseAck,
  input wire logic bypassTiming
);
  localparam int CIC_BIT = $clog2(COL_MUX);
  localparam logic [AW-1:0] ADDR_MAX = '1;
  localparam logic [DW-1:0] CHK5 = {(DW / 2){2'b01}};
  localparam logic [DW-1:0] CHKA = {(DW / 2){2'b10}};
  localparam bit BYP_PRESENT = (BYPASS_KIND != mbb_pkg::BYP_NONE);

  typedef struct packed {
    mbb_pkg::mbb_state_t st;
    logic [mbb_pkg::CTRL_W-1:0] ctrl;
    logic [DW-1:0] bgA;
    logic [DW-1:0] bgB;
    logic [31:0] holdCfg;
    logic [31:0] cnt;
    logic [AW-1:0] addr;
    logic [2:0] bgIdx;
    logic done;
    logic fail;
    logic rdPend;
    logic [DW-1:0] expData;
    logic ackS1;
    logic ackS2;
    logic bckS1;
    logic bckS2;
    logic bckPrev;
    logic [AW-1:0] memAddr;
    logic [DW-1:0] memWData;
    logic memWe;
    logic memCs;
    logic [DW-1:0] funcRData;
    logic pauseReq;
    logic clkTie0;
    logic clkTest;
    logic clkFunc;
    logic scanToTest;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mbb_top_st_t;

  mbb_top_st_t r_reg;
  mbb_top_st_t r_next;

  mbb_byp_if #(.DW(DW)) bypLink ();

  mbb_bypass_bank #(
    .DW(DW),
    .SHARE(SHARE),
    .KIND(BYPASS_KIND)
  ) u_bank (
    .core_clk(core_clk),
    .resetn(resetn),
    .byp(bypLink.bank)
  );

  // Number of background words the selection and custom options produce
  function automatic logic [2:0] bgCount(input logic [mbb_pkg::CTRL_W-1:0] c);
    logic [2:0] ck;
    ck = c[mbb_pkg::CTRL_CUSTOM] ? 3'h4 : 3'h2;
    case (c[mbb_pkg::CTRL_BGSEL_LO +: 2]) // [R17]
      mbb_pkg::BGSEL_UNIFORM: bgCount = 3'h1;
      mbb_pkg::BGSEL_CHECKER: bgCount = ck;
      default: bgCount = ck + 3'h1;
    endcase
  endfunction : bgCount

  // Background word k of the selected list, before address inversion
  function automatic logic [DW-1:0] bgWord(input logic [mbb_pkg::CTRL_W-1:0] c,
                                           input logic [DW-1:0] a,
                                           input logic [DW-1:0] b,
                                           input logic [2:0] k);
    logic hasUni;
    logic [2:0] j;
    logic two;
    hasUni = (c[mbb_pkg::CTRL_BGSEL_LO +: 2] != mbb_pkg::BGSEL_CHECKER);
    j = k - {2'h0, hasUni};
    two = c[mbb_pkg::CTRL_TWO_CUSTOM];
    if (hasUni && k == 3'h0)
      bgWord = c[mbb_pkg::CTRL_CUSTOM] ? a : '0; // [R3]
    else if (!c[mbb_pkg::CTRL_CUSTOM])
      bgWord = (j == 3'h0) ? CHK5 : CHKA;
    else
    begin
      case (j)
        3'h0: bgWord = a; // [R4] [R5]
        3'h1: bgWord = ~a;
        3'h2: bgWord = two ? b : CHK5; // [R5] [R4]
        default: bgWord = two ? ~b : CHKA;
      endcase
    end
  endfunction : bgWord

  // Address-dependent inversion applied to the current word
  function automatic logic [DW-1:0] applyInv(input logic [mbb_pkg::CTRL_W-1:0] c,
                                             input logic [DW-1:0] w,
                                             input logic [AW-1:0] ad);
    logic inv;
    inv = (c[mbb_pkg::CTRL_ALT_INV] & ad[0]) // [R1]
        ^ (c[mbb_pkg::CTRL_COL_INV] & ad[CIC_BIT]); // [R2] [R18]
    applyInv = inv ? ~w : w;
  endfunction : applyInv

  logic [DW-1:0] curWord;
  logic [31:0] holdLen;
  logic testRun;
  logic bypassOn;
  logic [DW-1:0] addrFold;

  // Address inputs folded down to data width for the merged scan observation view
  always_comb
  begin
    addrFold = '0;
    for (int i = 0; i < AW; i++)
    begin
      addrFold[i % DW] = addrFold[i % DW] ^ funcAddr[i];
    end
  end

  assign curWord = applyInv(r_reg.ctrl, bgWord(r_reg.ctrl, r_reg.bgA, r_reg.bgB,
                            r_reg.bgIdx), r_reg.addr);
  // Longer configured hold overrides the default pause
  assign holdLen = (r_reg.holdCfg > HOLD_CYCLES) ? r_reg.holdCfg : HOLD_CYCLES; // [R7]
  assign testRun = (r_reg.st != mbb_pkg::ST_IDLE);
  assign bypassOn = BYP_PRESENT && r_reg.ctrl[mbb_pkg::CTRL_BYPASS] && !testRun; // [R9]
  assign bypLink.merged = funcWData ^ addrFold ^ {DW{funcWe}} ^ {DW{funcCs}}; // [R10]
  // Dedicated timing input strobes capture on its rising edge only
  assign bypLink.capEn = DED_BYP_CLK ? (r_reg.bckS2 & ~r_reg.bckPrev) : 1'b1; // [R15]

  // Next-state logic: APB slave, retention sequencer and memory drive
  always_comb
  begin
    logic wrAcc;
    logic startReq;
    wrAcc = psel & penable & r_reg.pready & pwrite;
    startReq = 1'b0;
    r_next = r_reg;
    r_next.ackS1 = pauseAck;
    r_next.ackS2 = r_reg.ackS1;
    r_next.bckS1 = bypassTiming;
    r_next.bckS2 = r_reg.bckS1;
    r_next.bckPrev = r_reg.bckS2;
    r_next.rdPend = 1'b0;
    // One wait state lets read data come from a flop
    r_next.pready = psel & penable & ~r_reg.pready;
    if (psel && penable && !r_reg.pready)
    begin
      r_next.pslverr = 1'b0;
      r_next.prdata = '0;
      if (paddr == mbb_pkg::OFF_CTRL)
        r_next.prdata[mbb_pkg::CTRL_W-1:0] = r_reg.ctrl;
      else if (paddr == mbb_pkg::OFF_BG_A)
        r_next.prdata[DW-1:0] = r_reg.bgA;
      else if (paddr == mbb_pkg::OFF_BG_B)
        r_next.prdata[DW-1:0] = r_reg.bgB;
      else if (paddr == mbb_pkg::OFF_HOLD)
        r_next.prdata = r_reg.holdCfg;
      else if (paddr == mbb_pkg::OFF_STATUS)
      begin
        r_next.prdata[7:0] = r_reg.st;
        r_next.prdata[mbb_pkg::STAT_BUSY] = testRun;
        r_next.prdata[mbb_pkg::STAT_DONE] = r_reg.done;
        r_next.prdata[mbb_pkg::STAT_FAIL] = r_reg.fail;
        r_next.prdata[mbb_pkg::STAT_PAUSE] = r_reg.pauseReq;
        r_next.prdata[mbb_pkg::STAT_IDX_LO +: 3] = r_reg.bgIdx;
        r_next.prdata[mbb_pkg::STAT_ADDR_LO +: AW] = r_reg.addr;
      end
      else
        r_next.pslverr = 1'b1;
    end
    if (wrAcc)
    begin
      if (paddr == mbb_pkg::OFF_CTRL)
      begin
        r_next.ctrl = pwdata[mbb_pkg::CTRL_W-1:0];
        r_next.ctrl[mbb_pkg::CTRL_START] = 1'b0;
        startReq = pwdata[mbb_pkg::CTRL_START] && !testRun;
      end
      else if (paddr == mbb_pkg::OFF_BG_A)
        r_next.bgA = pwdata[DW-1:0];
      else if (paddr == mbb_pkg::OFF_BG_B)
        r_next.bgB = pwdata[DW-1:0];
      else if (paddr == mbb_pkg::OFF_HOLD)
        r_next.holdCfg = pwdata;
    end
    // Default memory drive: idle chip select, no write
    r_next.memWe = 1'b0;
    r_next.memCs = ~CS_ACT_HIGH;
    case (r_reg.st)
      mbb_pkg::ST_IDLE:
      begin
        if (startReq)
        begin
          r_next.done = 1'b0;
          r_next.fail = 1'b0;
          r_next.bgIdx = '0;
          r_next.addr = ADDR_MAX;
          r_next.st = mbb_pkg::ST_WRB;
        end
      end
      mbb_pkg::ST_WRB, mbb_pkg::ST_WRA, mbb_pkg::ST_RDB, mbb_pkg::ST_RDA:
      begin
        // b is the inverse background; b elements walk downward
        r_next.memCs = CS_ACT_HIGH;
        r_next.memAddr = r_reg.addr;
        r_next.memWe = (r_reg.st == mbb_pkg::ST_WRB) || (r_reg.st == mbb_pkg::ST_WRA);
        r_next.memWData = (r_reg.st == mbb_pkg::ST_WRB) ? ~curWord : curWord;
        r_next.expData = (r_reg.st == mbb_pkg::ST_RDB) ? ~curWord : curWord;
        r_next.rdPend = (r_reg.st == mbb_pkg::ST_RDB) || (r_reg.st == mbb_pkg::ST_RDA);
        r_next.cnt = '0;
        if (r_reg.st == mbb_pkg::ST_WRB || r_reg.st == mbb_pkg::ST_RDB)
        begin
          r_next.addr = r_reg.addr - 1'b1;
          if (r_reg.addr == '0)
          begin
            r_next.addr = '0;
            r_next.st = (r_reg.st == mbb_pkg::ST_WRB) ? mbb_pkg::ST_P1
                      : mbb_pkg::ST_WRA; // [R8]
          end
        end
        else
        begin
          r_next.addr = r_reg.addr + 1'b1;
          if (r_reg.addr == ADDR_MAX)
          begin
            r_next.addr = '0;
            if (r_reg.st == mbb_pkg::ST_WRA)
              r_next.st = mbb_pkg::ST_P2; // [R8]
            else if (r_reg.bgIdx == bgCount(r_reg.ctrl) - 3'h1)
              r_next.st = mbb_pkg::ST_DONE;
            else
            begin
              r_next.bgIdx = r_reg.bgIdx + 3'h1;
              r_next.addr = ADDR_MAX;
              r_next.st = mbb_pkg::ST_WRB;
            end
          end
        end
      end
      mbb_pkg::ST_P1, mbb_pkg::ST_P2:
      begin
        // Memory idles with chip select off during the pause
        if (r_reg.ctrl[mbb_pkg::CTRL_HANDSHAKE]) // [R6]
        begin
          r_next.pauseReq = ~r_reg.ackS2; // [R19]
          if (r_reg.pauseReq && r_reg.ackS2)
          begin
            r_next.pauseReq = 1'b0;
            r_next.st = (r_reg.st == mbb_pkg::ST_P1) ? mbb_pkg::ST_RDB : mbb_pkg::ST_RDA;
            r_next.addr = (r_reg.st == mbb_pkg::ST_P1) ? ADDR_MAX : '0;
          end
        end
        else
        begin
          r_next.cnt = r_reg.cnt + 32'h1; // [R6] [R7]
          if (r_reg.cnt >= holdLen - 32'h1)
          begin
            r_next.st = (r_reg.st == mbb_pkg::ST_P1) ? mbb_pkg::ST_RDB : mbb_pkg::ST_RDA;
            r_next.addr = (r_reg.st == mbb_pkg::ST_P1) ? ADDR_MAX : '0;
          end
        end
      end
      default:
      begin
        r_next.done = 1'b1;
        r_next.st = mbb_pkg::ST_IDLE;
      end
    endcase
    // Mismatch on read data one cycle after the read
    if (r_reg.rdPend && memRData != r_reg.expData)
      r_next.fail = 1'b1;
    // Functional and bypass traffic when no test runs
    if (!testRun && r_next.st == mbb_pkg::ST_IDLE)
    begin
      r_next.memAddr = funcAddr;
      r_next.memWData = funcWData;
      r_next.memWe = funcWe && !bypassOn;
      r_next.memCs = funcCs;
      if (bypassOn && r_reg.ctrl[mbb_pkg::CTRL_MEM_DIS])
      begin
        r_next.memCs = ~CS_ACT_HIGH; // [R12]
        r_next.memWe = 1'b0;
      end
    end
    r_next.funcRData = bypassOn ? bypLink.q : memRData; // [R10] [R14]
    r_next.clkTie0 = bypassOn && r_reg.ctrl[mbb_pkg::CTRL_MEM_DIS]; // [R13]
    r_next.scanToTest = bypassOn && MULTI_CLK; // [R11]
    r_next.clkFunc = FUNC_CLK_TIE && CLOCK_TRACE; // [R16]
    r_next.clkTest = testRun || (bypassOn && MULTI_CLK);
  end

  // Register the whole state; all outputs come from these flops
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_reg <= '0;
      r_reg.st <= mbb_pkg::ST_IDLE;
      r_reg.ctrl <= mbb_pkg::CTRL_RST;
      r_reg.holdCfg <= mbb_pkg::HOLD_RST;
      r_reg.memCs <= ~CS_ACT_HIGH;
    end
    else
      r_reg <= r_next;
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign funcRData = r_reg.funcRData;
  assign memAddr = r_reg.memAddr;
  assign memWData = r_reg.memWData;
  assign memWe = r_reg.memWe;
  assign memCs = r_reg.memCs;
  assign memClkTieLow = r_reg.clkTie0;
  assign memClkUseTest = r_reg.clkTest;
  assign testClkFromFunc = r_reg.clkFunc;
  assign scanClkToTest = r_reg.scanToTest;
  assign pauseReq = r_reg.pauseReq;
endmodule : mbb_top

// ---- bench/mbb_ram_model.sv ----
// Behavioural RAM that sits behind the generator's memory pins.
// Assumes an active-high select; read data stands with the address.
module mbb_ram_model #(
  parameter int DW = 8,
  parameter int AW = 4
) (
  input wire logic core_clk,
  input wire logic [AW-1:0] memAddr,
  input wire logic [DW-1:0] memWData,
  input wire logic memWe,
  input wire logic memCs,
  input wire logic [AW:0] faultAddr,
  output logic [DW-1:0] memRData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DW-1:0] mem [2 ** AW];
  logic [DW-1:0] last_reg = '0;
  // Read data follows the pins; idle shows the last read inverted
  assign memRData = (memCs && !memWe) ? mem[memAddr] ^ DW'(faultAddr == {1'h0, memAddr})
    : ~last_reg;
  always @(posedge core_clk)
  begin
    if (memCs && memWe)
      mem[memAddr] <= memWData;
    if (memCs && !memWe)
      last_reg <= memRData;
  end
endmodule : mbb_ram_model

// ---- bench/mbb_checker.sv ----
// Port-level assertions for the generator and bypass.
// Bound into mbb_top; CTRL bits are shadowed from APB writes.
module mbb_checker #(
  parameter int DW = 8,
  parameter int AW = 6,
  parameter int COL_MUX = 4,
  parameter bit CS_ACT_HIGH = 1'h1,
  parameter bit MULTI_CLK = 1'h1,
  parameter bit FUNC_CLK_TIE = 1'h0,
  parameter bit CLOCK_TRACE = 1'h1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [DW-1:0] funcRData,
  input wire logic [AW-1:0] memAddr,
  input wire logic [DW-1:0] memWData,
  input wire logic memWe,
  input wire logic memCs,
  input wire logic [DW-1:0] memRData,
  input wire logic memClkTieLow,
  input wire logic memClkUseTest,
  input wire logic testClkFromFunc,
  input wire logic scanClkToTest,
  input wire logic pauseReq,
  input wire logic pauseAck
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CB = $clog2(COL_MUX);
  logic alt_reg, col_reg, prevWr_reg, warm_reg, flip;
  logic [AW-1:0] prevAddr_reg;
  logic [DW-1:0] prevData_reg;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // Shadow the inversion enables and the last write
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      {alt_reg, col_reg, prevWr_reg, warm_reg} <= 4'h0;
    else
    begin
      warm_reg <= 1'h1;
      prevWr_reg <= memWe && memCs == CS_ACT_HIGH;
      prevAddr_reg <= memAddr;
      prevData_reg <= memWData;
      if (psel && penable && pready && pwrite && !pslverr && paddr == mbb_pkg::OFF_CTRL)
        {col_reg, alt_reg} <= pwdata[2:1];
    end
  end
  assign flip = (alt_reg & (memAddr[0] ^ prevAddr_reg[0])) ^
    (col_reg & (memAddr[CB] ^ prevAddr_reg[CB]));
  AST_INV_STEP:
    assert property (prevWr_reg && memWe && memCs == CS_ACT_HIGH && (memAddr ==
      prevAddr_reg + 1'h1 || prevAddr_reg == memAddr + 1'h1) |->
      memWData == (prevData_reg ^ {DW{flip}})) else $error("Bad background step");
  AST_FUNC_TIE:
    assert property (warm_reg |-> testClkFromFunc == (FUNC_CLK_TIE && CLOCK_TRACE))
    else $error("Functional clock tie wrong");
  AST_SCAN_CLK:
    assert property (scanClkToTest |-> memClkUseTest && MULTI_CLK)
    else $error("Scan clock not on test clock");
  AST_TIE_CS:
    assert property (memClkTieLow |-> memCs == !CS_ACT_HIGH) else $error("Select active");
  AST_TIE_BYPASS:
    assert property (memClkTieLow && MULTI_CLK |-> scanClkToTest)
    else $error("Clock tie outside bypass");
  AST_PAUSE_QUIET:
    assert property (pauseReq |-> memCs == !CS_ACT_HIGH) else $error("RAM busy in pause");
  AST_PAUSE_END:
    assert property (pauseReq && pauseAck |-> ##[1:4] !pauseReq) else $error("Pause stuck");
  AST_PAUSE_HOLD:
    assert property ((pauseReq && !pauseAck) [*3] |=> pauseReq) else $error("Pause cut");
  AST_FUNC_READ:
    assert property (warm_reg && !scanClkToTest && !$past(scanClkToTest) &&
      !$past(scanClkToTest, 2) |-> funcRData == $past(memRData))
    else $error("Read path wrong");
endmodule : mbb_checker

// ---- bench/mbb_top_tb.sv ----
// Self-checking bench: random backgrounds, pause timing and bypass.
// Assumes the RAM model as partner and a 25 MHz core clock.
module mbb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = 8;
  localparam int AW = 4;
  localparam int NA = 2 ** AW;
  localparam int HOLD = 20;
  localparam logic [AW:0] NOFAULT = {1'h1, AW'(0)};
  logic core_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, apbRd;
  logic pready, pslverr, apbErr, memWe, memCs, pauseReq, pauseAck = 1'h0;
  logic [AW-1:0] funcAddr = '0, memAddr;
  logic [DW-1:0] funcWData = '0, funcRData, memWData, memRData;
  logic funcWe = 1'h0, funcCs = 1'h0, bypassTiming = 1'h0, monOn = 1'h0, altOn, colOn;
  logic memClkTieLow, memClkUseTest, testClkFromFunc, scanClkToTest;
  logic [AW:0] faultAddr = NOFAULT;
  logic [DW-1:0] bgQ [$];
  int error_cnt = 0, check_count = 0, cycles = 0, wrCnt, rdCnt, idleRun, maxIdle;
  always #20 core_clk = ~core_clk;
  mbb_top #(.DW(DW), .AW(AW), .HOLD_CYCLES(32'(HOLD))) u_dut (.core_clk, .resetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .funcAddr, .funcWData,
    .funcWe, .funcCs, .funcRData, .memAddr, .memWData, .memWe, .memCs, .memRData,
    .memClkTieLow, .memClkUseTest, .testClkFromFunc, .scanClkToTest, .pauseReq, .pauseAck,
    .bypassTiming);
  mbb_ram_model #(.DW(DW), .AW(AW)) u_ram (.core_clk, .memAddr, .memWData, .memWe, .memCs,
    .faultAddr, .memRData);
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  // One APB transfer, held until pready is high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do
      @(posedge core_clk);
    while (pready !== 1'h1);
    apbRd = prdata;
    apbErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb
  // Slow strobe so the synchroniser sees each edge
  task automatic pulse();
    bypassTiming <= 1'h1;
    repeat (3) @(posedge core_clk);
    bypassTiming <= 1'h0;
    repeat (8) @(posedge core_clk);
  endtask : pulse
  // Score one RAM access against march order and data
  task automatic score(input logic wr);
    int i, g;
    logic [AW-1:0] ea;
    logic [DW-1:0] w;
    maxIdle = idleRun > maxIdle ? idleRun : maxIdle;
    idleRun = 0;
    i = wr ? wrCnt : rdCnt;
    g = i / NA;
    ea = AW'(g % 2 ? i % NA : NA - 1 - i % NA);
    check("address", 32'(ea), 32'(memAddr));
    if (wr && g / 2 < bgQ.size())
    begin
      w = g % 2 ? bgQ[g / 2] : ~bgQ[g / 2];
      w = w ^ {DW{altOn & ea[0] ^ colOn & ea[2]}};
      check("write data", 32'(w), 32'(memWData));
    end
    if (wr)
      wrCnt++;
    else
      rdCnt++;
  endtask : score
  // Watch RAM pins during a run
  always @(posedge core_clk)
  begin
    if (monOn && memCs !== 1'h1)
      idleRun++;
    else if (monOn)
      score(memWe === 1'h1);
  end
  // One self-test with random custom values
  task automatic run(input logic [9:0] c, input logic [31:0] h, input logic [AW:0] f);
    logic [DW-1:0] a, b;
    int n, hv;
    a = DW'($urandom);
    b = DW'($urandom);
    apb(1'h1, mbb_pkg::OFF_BG_A, 32'(a));
    apb(1'h1, mbb_pkg::OFF_BG_B, 32'(b));
    apb(1'h1, mbb_pkg::OFF_HOLD, h);
    bgQ = {};
    if (c[4:3] != mbb_pkg::BGSEL_CHECKER)
      bgQ.push_back(c[5] ? a : '0);
    if (c[4:3] != mbb_pkg::BGSEL_UNIFORM)
    begin
      if (c[5])
        bgQ = {bgQ, a, ~a};
      bgQ = {bgQ, c[5] && c[6] ? b : 8'h55, c[5] && c[6] ? ~b : 8'haa};
    end
    {colOn, altOn} = c[2:1];
    wrCnt = 0;
    rdCnt = 0;
    idleRun = 0;
    maxIdle = 0;
    faultAddr <= f;
    monOn = 1'h1;
    apb(1'h1, mbb_pkg::OFF_CTRL, 32'({c[9:1], 1'h1}));
    n = 0;
    do
      apb(1'h0, mbb_pkg::OFF_STATUS, 32'h0);
    while (apbRd[mbb_pkg::STAT_DONE] !== 1'h1 && ++n < 500);
    monOn = 1'h0;
    check("done", 32'h1, 32'(apbRd[mbb_pkg::STAT_DONE]));
    check("fail", 32'(!f[AW]), 32'(apbRd[mbb_pkg::STAT_FAIL]));
    check("writes", 32'(2 * NA * bgQ.size()), 32'(wrCnt));
    check("reads", 32'(2 * NA * bgQ.size()), 32'(rdCnt));
    hv = h > HOLD ? int'(h) : HOLD;
    if (!c[7])
      check("pause", 32'(hv), 32'(maxIdle));
  endtask : run
  // Pause handshake partner: ack after a random wait
  initial
  forever
  begin
    while (pauseReq !== 1'h1)
      @(posedge core_clk);
    repeat (3 + $urandom_range(5)) @(posedge core_clk);
    pauseAck <= 1'h1;
    while (pauseReq !== 1'h0)
      @(posedge core_clk);
    pauseAck <= 1'h0;
  end
  // Hang guard, far above the expected run time
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    logic [DW-1:0] d;
    void'($urandom(32'hf5b8));
    repeat (6) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    check("functional clock tie", 32'h0, 32'(testClkFromFunc));
    check("pause request", 32'h0, 32'(pauseReq));
    d = DW'($urandom);
    apb(1'h1, mbb_pkg::OFF_BG_B, 32'(d));
    apb(1'h0, mbb_pkg::OFF_BG_B, 32'h0);
    check("custom value", 32'(d), apbRd);
    apb(1'h0, 8'h14, 32'h0);
    check("unmapped error", 32'h1, 32'(apbErr));
    run(10'h02a, 32'h0, NOFAULT);
    run(10'h034, 32'h0, NOFAULT);
    run(10'h076, 32'h0, NOFAULT);
    run(10'h000, 32'h0, NOFAULT);
    run(10'h038, 32'h28, NOFAULT);
    run(10'h088, 32'h0, NOFAULT);
    run(10'h008, 32'h0, {1'h0, AW'(5)});
    // Bypass with memory disable
    apb(1'h1, mbb_pkg::OFF_CTRL, 32'h300);
    repeat (2) @(posedge core_clk);
    check("clock tie low", 32'h1, 32'(memClkTieLow));
    check("chip select", 32'h0, 32'(memCs));
    check("scan clock", 32'h1, 32'(scanClkToTest));
    funcWData <= 8'h10;
    pulse();
    check("bypass fold", 32'hf0, 32'(funcRData));
    d[3] = ^d[2:0];
    d[7] = ^d[6:4];
    funcWData <= d;
    pulse();
    check("bypass even fold", 32'h0, 32'(funcRData));
    funcWData <= 8'h01;
    repeat (6) @(posedge core_clk);
    check("bypass held", 32'h0, 32'(funcRData));
    pulse();
    check("bypass capture", 32'h0f, 32'(funcRData));
    apb(1'h1, mbb_pkg::OFF_CTRL, 32'h0);
    repeat (2) @(posedge core_clk);
    check("clock tie off", 32'h0, 32'(memClkTieLow));
    give_verdict();
  end
endmodule : mbb_top_tb
bind mbb_top mbb_checker #(.DW(DW), .AW(AW), .COL_MUX(COL_MUX), .CS_ACT_HIGH(CS_ACT_HIGH),
  .MULTI_CLK(MULTI_CLK), .FUNC_CLK_TIE(FUNC_CLK_TIE), .CLOCK_TRACE(CLOCK_TRACE)) u_chk (
  .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .funcRData, .memAddr, .memWData, .memWe, .memCs, .memRData, .memClkTieLow,
  .memClkUseTest, .testClkFromFunc, .scanClkToTest, .pauseReq, .pauseAck);
